// File: acdc_pkg.sv
package acdc_pkg;

   // ---------------------------------------------------------------
   // Register offsets on the control port
   // ---------------------------------------------------------------
   localparam logic [7:0] ACDC_ADDR_CP = 8'h1d;
   localparam logic [7:0] ACDC_ADDR_OSR = 8'h1e;
   localparam logic [7:0] ACDC_ADDR_BCK = 8'h20;
   localparam logic [7:0] ACDC_ADDR_LRK = 8'h21;
   localparam logic [7:0] ACDC_ADDR_ISM = 8'h22;
   localparam logic [7:0] ACDC_ADDR_CDC = 8'h25;

   // ---------------------------------------------------------------
   // Values after reset
   // ---------------------------------------------------------------
   localparam logic [6:0] ACDC_RST_CP = 7'h01;
   localparam logic [6:0] ACDC_RST_OSR = 7'h01;
   localparam logic [6:0] ACDC_RST_BCK = 7'h00;
   localparam logic [7:0] ACDC_RST_LRK = 8'h00;
   localparam logic ACDC_RST_INTERP = 1'b0;
   localparam logic [2:0] ACDC_RST_SPEED = 3'h4;
   localparam logic [6:0] ACDC_RST_CDC = 7'h00;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int ACDC_ISM_INTERP_BIT = 4;
   localparam int ACDC_ISM_SPEED_LSB = 0;
   localparam int ACDC_CDC_SKIP_RATE = 6;
   localparam int ACDC_CDC_SKIP_BCK = 5;
   localparam int ACDC_CDC_SKIP_MCK = 4;
   localparam int ACDC_CDC_SKIP_HALT = 3;
   localparam int ACDC_CDC_SKIP_MISS = 2;
   localparam int ACDC_CDC_AUTO_OFF = 1;
   localparam int ACDC_CDC_SKIP_PLL = 0;

   // ---------------------------------------------------------------
   // Speed mode codes and ratios used while auto setup is active
   // ---------------------------------------------------------------
   localparam logic [2:0] ACDC_SPEED_48K = 3'h3;
   localparam logic [2:0] ACDC_SPEED_96K = 3'h4;
   localparam logic [2:0] ACDC_SPEED_32K = 3'h7;
   localparam logic [2:0] ACDC_AUTO_SPEED = 3'h3;
   localparam logic [7:0] ACDC_AUTO_CP_DIV = 8'h03;
   localparam logic [7:0] ACDC_AUTO_OSR_DIV = 8'h01;

   // ---------------------------------------------------------------
   // Bit clock per frame limits and divider indices
   // ---------------------------------------------------------------
   localparam logic [9:0] ACDC_BCK_RATIO_MIN = 10'h020;
   localparam logic [9:0] ACDC_BCK_RATIO_MAX = 10'h100;
   localparam logic [9:0] ACDC_BCK_CNT_SAT = 10'h3ff;
   localparam int ACDC_NUM_DIV = 4;
   localparam int ACDC_DIV_CP = 0;
   localparam int ACDC_DIV_OSR = 1;
   localparam int ACDC_DIV_BCK = 2;
   localparam int ACDC_DIV_LRK = 3;
   localparam int ACDC_NUM_PINS = 8;

   typedef enum logic [1:0] {
      ACDC_RATE_48K,
      ACDC_RATE_96K,
      ACDC_RATE_32K,
      ACDC_RATE_RSVD
   } acdc_rate_e;

endpackage : acdc_pkg

// File: acdc_div_if.sv
`timescale 1ns/1ps
interface acdc_div_if;
   logic [7:0] period;
   logic run;
   logic advance;
   logic level;
   logic tick;
   modport ctrl (output period, output run, output advance, input level, input tick);
   modport div (input period, input run, input advance, output level, output tick);
endinterface : acdc_div_if

// File: acdc_divider.sv
`timescale 1ns/1ps
module acdc_divider (
   input wire logic clk,
   input wire logic nrst,
   acdc_div_if.div dv
);
   import acdc_pkg::*;

   logic [7:0] cnt_q;
   logic [7:0] period_q;
   logic level_q;
   logic tick_q;
   logic [7:0] cnt_d;

   assign cnt_d = cnt_q + 8'h01;
   assign dv.level = level_q;
   assign dv.tick = tick_q;

   // ---------------------------------------------------------------
   // Counter; a new ratio is taken when a period ends or while run is low.
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 8'h00;
         period_q <= 8'h00;
         level_q <= 1'b0;
         tick_q <= 1'b0;
      end else if (!dv.run) begin
         cnt_q <= 8'h00;
         period_q <= dv.period;
         level_q <= 1'b0;
         tick_q <= 1'b0;
      end else if (dv.advance) begin
         if (cnt_q == period_q) begin
            cnt_q <= 8'h00;
            period_q <= dv.period;
            level_q <= 1'b1;
            tick_q <= 1'b1;
         end else begin
            cnt_q <= cnt_d;
            level_q <= (cnt_d <= {1'b0, period_q[7:1]});
            tick_q <= 1'b0;
         end
      end else begin
         tick_q <= 1'b0;
      end
   end

endmodule : acdc_divider

// File: acdc_clock_config.sv
`timescale 1ns/1ps
module acdc_clock_config (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_q,
   input wire logic master_mode_pin,
   input wire logic pll_lock_pin,
   input wire logic rate_err_pin,
   input wire logic mclk_err_pin,
   input wire logic halt_err_pin,
   input wire logic clk_missing_pin,
   input wire logic ext_bck_pin,
   input wire logic ext_lrck_pin,
   output logic charge_pump_clock_q,
   output logic oversampling_clock_q,
   output logic bck_out_q,
   output logic lrck_out_q,
   output logic interp_16x_q,
   output acdc_pkg::acdc_rate_e rate_mode_q,
   output logic clock_error_q,
   output logic pll_lock_status_q,
   output logic dac_powerdown_q,
   output logic bck_ratio_err_q
);
   import acdc_pkg::*;

   // ---------------------------------------------------------------
   // Decoding helpers
   // ---------------------------------------------------------------
   function automatic acdc_rate_e acdc_decode_speed(input logic [2:0] code);
      acdc_rate_e r;
      r = ACDC_RATE_RSVD;
      case (code)
         ACDC_SPEED_48K: r = ACDC_RATE_48K;
         ACDC_SPEED_96K: r = ACDC_RATE_96K;
         ACDC_SPEED_32K: r = ACDC_RATE_32K;
         default: r = ACDC_RATE_RSVD;
      endcase
      return r;
   endfunction : acdc_decode_speed

   function automatic logic acdc_hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction : acdc_hit

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // Reserved bits are not stored and always read back as zero.
   logic [6:0] charge_pump_div_value_q;
   logic [6:0] oversample_div_value_q;
   logic [6:0] master_bitclk_div_value_q;
   logic [7:0] master_frameclk_div_value_q;
   logic interp_ratio_select_q;
   logic [2:0] rate_speed_mode_q;
   logic [6:0] cdc_q;
   logic auto_on;

   assign auto_on = !cdc_q[ACDC_CDC_AUTO_OFF];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         charge_pump_div_value_q <= ACDC_RST_CP;
         oversample_div_value_q <= ACDC_RST_OSR;
         master_bitclk_div_value_q <= ACDC_RST_BCK;
         master_frameclk_div_value_q <= ACDC_RST_LRK;
         interp_ratio_select_q <= ACDC_RST_INTERP;
         rate_speed_mode_q <= ACDC_RST_SPEED;
         cdc_q <= ACDC_RST_CDC;
      end else if (reg_wr) begin
         if (acdc_hit(reg_addr, ACDC_ADDR_CP)) begin
            charge_pump_div_value_q <= reg_wdata[6:0];
         end
         if (acdc_hit(reg_addr, ACDC_ADDR_OSR)) begin
            oversample_div_value_q <= reg_wdata[6:0];
         end
         if (acdc_hit(reg_addr, ACDC_ADDR_BCK)) begin
            master_bitclk_div_value_q <= reg_wdata[6:0];
         end
         if (acdc_hit(reg_addr, ACDC_ADDR_LRK)) begin
            master_frameclk_div_value_q <= reg_wdata;
         end
         if (acdc_hit(reg_addr, ACDC_ADDR_ISM)) begin
            interp_ratio_select_q <= reg_wdata[ACDC_ISM_INTERP_BIT];
            rate_speed_mode_q <= reg_wdata[ACDC_ISM_SPEED_LSB +: 3];
         end
         if (acdc_hit(reg_addr, ACDC_ADDR_CDC)) begin
            cdc_q <= reg_wdata[6:0];
         end
      end
   end

   // Read data is presented one cycle after the read strobe; unmapped reads return zero.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            ACDC_ADDR_CP: reg_rdata_q <= {1'b0, charge_pump_div_value_q};
            ACDC_ADDR_OSR: reg_rdata_q <= {1'b0, oversample_div_value_q};
            ACDC_ADDR_BCK: reg_rdata_q <= {1'b0, master_bitclk_div_value_q};
            ACDC_ADDR_LRK: reg_rdata_q <= master_frameclk_div_value_q;
            ACDC_ADDR_ISM: reg_rdata_q <= {3'h0, interp_ratio_select_q, 1'b0, rate_speed_mode_q};
            ACDC_ADDR_CDC: reg_rdata_q <= {1'b0, cdc_q};
            default: reg_rdata_q <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // Every pin passes two flip-flops so that a late edge never reaches the decoders.
   logic [ACDC_NUM_PINS-1:0] pin_raw;
   logic [ACDC_NUM_PINS-1:0] pin_s1_q;
   logic [ACDC_NUM_PINS-1:0] pin_s2_q;
   logic bck_s3_q;
   logic lrck_s3_q;

   assign pin_raw = {ext_lrck_pin,
                     ext_bck_pin,
                     clk_missing_pin,
                     halt_err_pin,
                     mclk_err_pin,
                     rate_err_pin,
                     pll_lock_pin,
                     master_mode_pin};

   genvar gp;
   generate
      for (gp = 0; gp < ACDC_NUM_PINS; gp++) begin : g_sync
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               pin_s1_q[gp] <= 1'b0;
               pin_s2_q[gp] <= 1'b0;
            end else begin
               pin_s1_q[gp] <= pin_raw[gp];
               pin_s2_q[gp] <= pin_s1_q[gp];
            end
         end
      end
   endgenerate

   logic master_s;
   logic pll_lock_s;
   logic rate_err_s;
   logic mclk_err_s;
   logic halt_err_s;
   logic missing_s;
   assign master_s = pin_s2_q[0];
   assign pll_lock_s = pin_s2_q[1];
   assign rate_err_s = pin_s2_q[2];
   assign mclk_err_s = pin_s2_q[3];
   assign halt_err_s = pin_s2_q[4];
   assign missing_s = pin_s2_q[5];

   // ---------------------------------------------------------------
   // Bit clock per frame check
   // ---------------------------------------------------------------
   logic bck_rise;
   logic lrck_rise;
   logic [9:0] bck_cnt_q;
   logic [9:0] bck_last_q;
   assign bck_rise = pin_s2_q[6] && !bck_s3_q;
   assign lrck_rise = pin_s2_q[7] && !lrck_s3_q;

   // A frame whose bit clock count differs from the frame before counts as unstable.
   logic bck_out_of_range;
   logic bck_unstable;
   assign bck_out_of_range = (bck_cnt_q < ACDC_BCK_RATIO_MIN) ||
                             (bck_cnt_q > ACDC_BCK_RATIO_MAX);
   assign bck_unstable = bck_cnt_q != bck_last_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bck_s3_q <= 1'b0;
         lrck_s3_q <= 1'b0;
         bck_cnt_q <= 10'h000;
         bck_last_q <= 10'h000;
         bck_ratio_err_q <= 1'b0;
      end else begin
         bck_s3_q <= pin_s2_q[6];
         lrck_s3_q <= pin_s2_q[7];
         if (lrck_rise) begin
            bck_cnt_q <= {9'h000, bck_rise};
            bck_last_q <= bck_cnt_q;
            bck_ratio_err_q <= bck_out_of_range || bck_unstable;
         end else if (bck_rise && bck_cnt_q != ACDC_BCK_CNT_SAT) begin
            bck_cnt_q <= bck_cnt_q + 10'h001;
         end
      end
   end

   // ---------------------------------------------------------------
   // Clock error and status
   // ---------------------------------------------------------------
   // Each detector failure counts only while its ignore bit is clear.
   logic rate_fail;
   logic bck_fail;
   logic mclk_fail;
   logic halt_fail;
   logic pll_fail;
   logic missing_fail;
   assign rate_fail = rate_err_s && !cdc_q[ACDC_CDC_SKIP_RATE];
   assign bck_fail = bck_ratio_err_q && !cdc_q[ACDC_CDC_SKIP_BCK];
   assign mclk_fail = mclk_err_s && !cdc_q[ACDC_CDC_SKIP_MCK];
   assign halt_fail = halt_err_s && !cdc_q[ACDC_CDC_SKIP_HALT];
   assign pll_fail = !pll_lock_s && !cdc_q[ACDC_CDC_SKIP_PLL];
   assign missing_fail = missing_s && !cdc_q[ACDC_CDC_SKIP_MISS];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clock_error_q <= 1'b0;
         pll_lock_status_q <= 1'b0;
         dac_powerdown_q <= 1'b0;
      end else begin
         clock_error_q <= rate_fail || bck_fail || mclk_fail || halt_fail || pll_fail;
         // The lock flag follows the real lock state whatever the ignore bit says.
         pll_lock_status_q <= pll_lock_s;
         dac_powerdown_q <= missing_fail;
      end
   end

   // ---------------------------------------------------------------
   // Interpolation and speed mode
   // ---------------------------------------------------------------
   // While auto setup is on, the built-in speed code replaces the programmed one.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         interp_16x_q <= ACDC_RST_INTERP;
         rate_mode_q <= ACDC_RATE_96K;
      end else begin
         interp_16x_q <= interp_ratio_select_q;
         rate_mode_q <= acdc_decode_speed(auto_on ? ACDC_AUTO_SPEED : rate_speed_mode_q);
      end
   end

   // ---------------------------------------------------------------
   // Dividers
   // ---------------------------------------------------------------
   // A ratio written mid-period waits for the divider to wrap, so no runt pulse appears.
   // The programmed charge pump and oversampling ratios are kept while auto setup runs, only not used.
   acdc_div_if dv_if [ACDC_NUM_DIV] ();

   assign dv_if[ACDC_DIV_CP].period = auto_on ? ACDC_AUTO_CP_DIV
                                              : {1'b0, charge_pump_div_value_q};
   assign dv_if[ACDC_DIV_CP].run = 1'b1;
   assign dv_if[ACDC_DIV_CP].advance = 1'b1;
   assign dv_if[ACDC_DIV_OSR].period = auto_on ? ACDC_AUTO_OSR_DIV
                                               : {1'b0, oversample_div_value_q};
   assign dv_if[ACDC_DIV_OSR].run = 1'b1;
   assign dv_if[ACDC_DIV_OSR].advance = 1'b1;
   assign dv_if[ACDC_DIV_BCK].period = {1'b0, master_bitclk_div_value_q};
   assign dv_if[ACDC_DIV_BCK].run = master_s;
   assign dv_if[ACDC_DIV_BCK].advance = 1'b1;
   assign dv_if[ACDC_DIV_LRK].period = master_frameclk_div_value_q;
   assign dv_if[ACDC_DIV_LRK].run = master_s;
   assign dv_if[ACDC_DIV_LRK].advance = dv_if[ACDC_DIV_BCK].tick;

   genvar gd;
   generate
      for (gd = 0; gd < ACDC_NUM_DIV; gd++) begin : g_div
         acdc_divider u_div (
            .clk(clk),
            .nrst(nrst),
            .dv(dv_if[gd])
         );
      end
   endgenerate

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         charge_pump_clock_q <= 1'b0;
         oversampling_clock_q <= 1'b0;
         bck_out_q <= 1'b0;
         lrck_out_q <= 1'b0;
      end else begin
         charge_pump_clock_q <= dv_if[ACDC_DIV_CP].level;
         oversampling_clock_q <= dv_if[ACDC_DIV_OSR].level;
         bck_out_q <= dv_if[ACDC_DIV_BCK].level;
         lrck_out_q <= dv_if[ACDC_DIV_LRK].level;
      end
   end

endmodule : acdc_clock_config

// File: acdc_clock_config_asserts.sv
`timescale 1ns/1ps
module acdc_clock_config_asserts
   import acdc_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic master_mode_pin,
   input wire logic pll_lock_pin,
   input wire logic rate_err_pin,
   input wire logic mclk_err_pin,
   input wire logic halt_err_pin,
   input wire logic clk_missing_pin,
   input wire logic bck_out_q,
   input wire logic lrck_out_q,
   input wire logic interp_16x_q,
   input wire logic clock_error_q,
   input wire logic pll_lock_status_q,
   input wire logic dac_powerdown_q,
   input wire logic bck_ratio_err_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   bck_idle_a: assert property (!master_mode_pin [*6] |-> !bck_out_q)
      else $error("bit clock runs while not master");
   lrck_idle_a: assert property (!master_mode_pin [*6] |-> !lrck_out_q)
      else $error("frame clock runs while not master");
   frame_align_a: assert property ($rose(lrck_out_q) |-> $past(bck_out_q))
      else $error("frame clock starts without a bit clock high phase before it");
   interp_field_a: assert property (reg_wr && reg_addr == ACDC_ADDR_ISM ##1 !reg_wr [*2]
      |-> interp_16x_q == $past(reg_wdata[4], 2))
      else $error("interpolation output differs from written bit");
   pll_status_a: assert property (pll_lock_pin [*4] |-> pll_lock_status_q)
      else $error("lock status low while locked");
   pll_loss_a: assert property (!pll_lock_pin [*4] |-> !pll_lock_status_q)
      else $error("lock status high while unlocked");
   error_idle_a: assert property ((pll_lock_pin && !rate_err_pin && !mclk_err_pin
      && !halt_err_pin && !bck_ratio_err_q) [*4] |-> !clock_error_q)
      else $error("clock error without a cause");
   powerdown_idle_a: assert property (!clk_missing_pin [*4] |-> !dac_powerdown_q)
      else $error("powerdown without missing clock");
endmodule : acdc_clock_config_asserts

bind acdc_clock_config acdc_clock_config_asserts acdc_clock_config_asserts_i (
   .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .master_mode_pin(master_mode_pin), .pll_lock_pin(pll_lock_pin),
   .rate_err_pin(rate_err_pin), .mclk_err_pin(mclk_err_pin), .halt_err_pin(halt_err_pin),
   .clk_missing_pin(clk_missing_pin), .bck_out_q(bck_out_q), .lrck_out_q(lrck_out_q),
   .interp_16x_q(interp_16x_q), .clock_error_q(clock_error_q),
   .pll_lock_status_q(pll_lock_status_q), .dac_powerdown_q(dac_powerdown_q),
   .bck_ratio_err_q(bck_ratio_err_q)
);

// File: acdc_clock_config_test.sv
`timescale 1ns/1ps
module acdc_clock_config_test;
   import acdc_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic master_mode_pin = 1'b0;
   logic pll_lock_pin = 1'b1;
   logic rate_err_pin = 1'b0;
   logic mclk_err_pin = 1'b0;
   logic halt_err_pin = 1'b0;
   logic clk_missing_pin = 1'b0;
   logic ext_bck_pin = 1'b0;
   logic ext_lrck_pin = 1'b0;
   logic [7:0] reg_rdata_q;
   logic charge_pump_clock_q, oversampling_clock_q, bck_out_q, lrck_out_q, interp_16x_q;
   logic clock_error_q, pll_lock_status_q, dac_powerdown_q, bck_ratio_err_q;
   acdc_rate_e rate_mode_q;
   logic [3:0] dsig;
   logic [7:0] rd_v;
   int n_fail = 0;
   int samples_checked = 0;
   int cycles = 0;

   assign dsig = {lrck_out_q, bck_out_q, oversampling_clock_q, charge_pump_clock_q};
   always #25 clk = ~clk;

   acdc_clock_config acdc_clock_config_i (
      .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .master_mode_pin(master_mode_pin),
      .pll_lock_pin(pll_lock_pin), .rate_err_pin(rate_err_pin), .mclk_err_pin(mclk_err_pin),
      .halt_err_pin(halt_err_pin), .clk_missing_pin(clk_missing_pin),
      .ext_bck_pin(ext_bck_pin), .ext_lrck_pin(ext_lrck_pin),
      .charge_pump_clock_q(charge_pump_clock_q), .oversampling_clock_q(oversampling_clock_q),
      .bck_out_q(bck_out_q), .lrck_out_q(lrck_out_q), .interp_16x_q(interp_16x_q),
      .rate_mode_q(rate_mode_q), .clock_error_q(clock_error_q),
      .pll_lock_status_q(pll_lock_status_q), .dac_powerdown_q(dac_powerdown_q),
      .bck_ratio_err_q(bck_ratio_err_q)
   );

   // ---------------------------------------------------------------
   // Shared bus cycles and comparison
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      @(negedge clk);
      d = reg_rdata_q;
   endtask : rd

   // Measures one full period of a derived clock, from rising edge to rising edge.
   // The first rise is skipped, since its period may still use the former ratio.
   task automatic div_chk(input string nm, input int s, input int v, input int mul);
      int per;
      int hi;
      int n;
      logic p;
      per = 0;
      hi = 0;
      n = 0;
      repeat (2) begin
         while (dsig[s] !== 1'b0 && n < 1500) begin
            @(negedge clk);
            n++;
         end
         while (dsig[s] !== 1'b1 && n < 1500) begin
            @(negedge clk);
            n++;
         end
      end
      do begin
         hi += int'(dsig[s]);
         per++;
         p = dsig[s];
         @(negedge clk);
      end while (!(dsig[s] === 1'b1 && p === 1'b0) && per < 1500);
      chk(nm, 12'((v + 1) * mul), 12'(per));
      if (mul == 1) chk(nm, 12'(v / 2 + 1), 12'(hi));
   endtask : div_chk

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      logic [7:0] ad [6] = '{8'h1d, 8'h1e, 8'h20, 8'h21, 8'h22, 8'h25};
      logic [7:0] rv [6] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h04, 8'h00};
      logic [7:0] mk [6] = '{8'h7f, 8'h7f, 8'h7f, 8'hff, 8'h17, 8'h7f};
      chk("interp reset", 12'h000, 12'(interp_16x_q));
      for (int i = 0; i < 6; i++) begin
         rd(ad[i], rd_v);
         chk("reset value", 12'(rv[i]), 12'(rd_v));
         wr(ad[i], 8'hff);
         rd(ad[i], rd_v);
         chk("write mask", 12'(mk[i]), 12'(rd_v));
      end
      wr(8'h1f, 8'hff);
      rd(8'h1f, rd_v);
      chk("unmapped", 12'h000, 12'(rd_v));
      chk("interp set", 12'h001, 12'(interp_16x_q));
   endtask : t_regs

   task automatic t_auto;
      wr(ACDC_ADDR_CDC, 8'h00);
      div_chk("auto cp", 0, 3, 1);
      div_chk("auto osr", 1, 1, 1);
      chk("auto rate", 12'(ACDC_RATE_48K), 12'(rate_mode_q));
   endtask : t_auto

   task automatic t_manual;
      logic [2:0] code [4] = '{3'h3, 3'h4, 3'h7, 3'h0};
      acdc_rate_e ex [4] = '{ACDC_RATE_48K, ACDC_RATE_96K, ACDC_RATE_32K, ACDC_RATE_RSVD};
      wr(ACDC_ADDR_CDC, 8'h22);
      wr(ACDC_ADDR_OSR, 8'h02);
      div_chk("cp", 0, 127, 1);
      div_chk("osr", 1, 2, 1);
      for (int i = 0; i < 4; i++) begin
         wr(ACDC_ADDR_ISM, {3'h0, i[0], 1'b0, code[i]});
         repeat (3) @(negedge clk);
         chk("rate", 12'(ex[i]), 12'(rate_mode_q));
         chk("interp", 12'(i[0]), 12'(interp_16x_q));
      end
   endtask : t_manual

   task automatic t_master;
      master_mode_pin = 1'b1;
      wr(ACDC_ADDR_BCK, 8'h01);
      wr(ACDC_ADDR_LRK, 8'h03);
      div_chk("bck", 2, 1, 1);
      div_chk("lrck", 3, 3, 2);
      wr(ACDC_ADDR_BCK, 8'h7f);
      div_chk("bck max", 2, 127, 1);
      wr(ACDC_ADDR_BCK, 8'h00);
      wr(ACDC_ADDR_LRK, 8'hff);
      div_chk("lrck max", 3, 255, 1);
      master_mode_pin = 1'b0;
      repeat (8) @(negedge clk);
      chk("bck idle", 12'h000, 12'({lrck_out_q, bck_out_q}));
   endtask : t_master

   task automatic t_err;
      int sk [5] = '{6, 4, 3, 0, 2};
      for (int i = 0; i < 5; i++) begin
         for (int v = 1; v >= 0; v--) begin
            rate_err_pin = (i == 0) && v;
            mclk_err_pin = (i == 1) && v;
            halt_err_pin = (i == 2) && v;
            pll_lock_pin = !((i == 3) && v);
            clk_missing_pin = (i == 4) && v;
            repeat (6) @(negedge clk);
            if (v == 1) begin
               chk("fault", 12'h001, 12'(i == 4 ? dac_powerdown_q : clock_error_q));
               wr(ACDC_ADDR_CDC, 8'h22 | (8'h01 << sk[i]));
               repeat (6) @(negedge clk);
               chk("masked", 12'h000, 12'(i == 4 ? dac_powerdown_q : clock_error_q));
               chk("lock flag", 12'(i != 3), 12'(pll_lock_status_q));
            end
         end
         wr(ACDC_ADDR_CDC, 8'h22);
      end
   endtask : t_err

   task automatic t_ratio;
      int nb [4] = '{32, 256, 257, 31};
      wr(ACDC_ADDR_CDC, 8'h02);
      for (int i = 0; i < 4; i++) begin
         repeat (3) begin
            for (int b = 0; b < nb[i]; b++) begin
               ext_lrck_pin = (b < nb[i] / 2);
               ext_bck_pin = 1'b0;
               repeat (4) @(negedge clk);
               ext_bck_pin = 1'b1;
               repeat (4) @(negedge clk);
            end
         end
         chk("ratio err", 12'(i >= 2), 12'(bck_ratio_err_q));
         chk("ratio clkerr", 12'(i >= 2), 12'(clock_error_q));
      end
   endtask : t_ratio

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict

   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         n_fail++;
         print_verdict();
      end
   end

   initial begin
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      t_regs();
      t_auto();
      t_manual();
      t_master();
      t_err();
      t_ratio();
      print_verdict();
   end
endmodule : acdc_clock_config_test
